// file: hw/maas_consts.svh
// Constants for the multiply/add/accumulate slice: register offsets,
// reset values and default widths.
// Assumes inclusion by bare name from the slice module and the bench.
`ifndef MAAS_CONSTS_SVH
`define MAAS_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define MAAS_CFG_OFS 4'h0
`define MAAS_STAT_OFS 4'h4

// Reset values
`define MAAS_CFG_RST 23'h000000
`define MAAS_CFG_W 23

// Accumulator width: full 36-bit product plus 16 growth bits
`define MAAS_ACC_W 52

// Shift chain lane widths
`define MAAS_LANE9 9
`define MAAS_LANE18 18

`endif

// file: hw/maas_pkg.sv
// Types shared by the multiply/add/accumulate slice.
// Assumes nothing of its surroundings.
`default_nettype none

package maas_pkg;

   // Multiplier size selection
   typedef enum logic [1:0] {W9, W18, W36, WRSV} maas_width_t;

   // Adder/output stage function
   typedef enum logic [1:0] {M_SIMPLE, M_ACC, M_ADD2, M_ADD4} maas_mode_t;

   // Configuration word, lowest field at bit 0
   typedef struct packed {
      logic sign_mul_reg;
      logic [1:0] out_set;
      logic [1:0] pipe_set;
      logic [1:0] b_set;
      logic [1:0] a_set;
      logic [1:0] sload_stg;
      logic [1:0] sign_stg;
      logic [1:0] addsub_stg;
      logic out_reg_en;
      logic pipe_en;
      logic shift_en;
      logic in_reg_en;
      maas_mode_t mode;
      maas_width_t width;
   } maas_cfg_t;

   // Dynamic controls travelling through the delay stages
   typedef struct packed {
      logic [1:0] sign;
      logic [1:0] addnsub;
      logic [1:0] sload;
   } maas_ctl_t;

endpackage

`default_nettype wire

// file: hw/maas_slice.sv
// Multiply/add/accumulate slice with Wishbone configuration registers.
// Assumes operands and controls come from fabric logic on clk_i.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "maas_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RULE1) A and B input registers use selected set
// (RULE2) Shift mode chains input registers outward
// (RULE3) Chain ends wherever downstream ignores it
// (RULE4) No input shifting in 36x36 size
// (RULE5) Eight 9x9, four 18x18, one 36x36
// (RULE6) Product signed if either operand signed
// (RULE7) Sign controls: 1 signed, optionally registered
// (RULE8) Products always full precision
// (RULE9) Optional pipeline register after multipliers
// (RULE10) Output register forced on for accumulation
// (RULE11) Adders add on high, subtract on low
// (RULE12) Add/subtract control delayed zero to two
// (RULE13) Adder signs share controls, up to two stages
// (RULE14) Accumulate with synchronous load of product
// (RULE15) Overflow flag registered and not sticky
// (RULE16) Summation: two sums or one sum
// (RULE17) Output mux picks product, accumulator, adder or sum
// (RULE18) Output registers use selected set
// (RULE19) Adders fed only from multiplier products
// (RULE20) Accumulator up to 52 bits wide
// (RULE21) One arithmetic mode per slice
// (RULE22) Clear zeroes registers of its set
module maas_slice #(
   parameter int ACC_W = `MAAS_ACC_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Shared enable and clear sets
   input wire logic [3:0] ena_i,
   input wire logic [3:0] aclr_i,
   // Operands and dynamic controls
   input wire logic [71:0] op_a_i,
   input wire logic [71:0] op_b_i,
   input wire logic sign_a_i,
   input wire logic sign_b_i,
   input wire logic [1:0] addnsub_i,
   input wire logic [1:0] accum_sload_i,
   // Input shift chain
   input wire logic [17:0] chain_in_first_operand_i,
   input wire logic [17:0] chain_in_second_operand_i,
   output logic [17:0] chain_out_first_operand_o,
   output logic [17:0] chain_out_second_operand_o,
   // Results
   output logic [143:0] result_o,
   output logic [1:0] overflow_o
);

   if (ACC_W < 38 || ACC_W > `MAAS_ACC_W) begin : g_bad_acc_w
      $error("ACC_W must lie between 38 and 52");
   end

   // Pick one member of the four shared sets
   function automatic logic pick(input logic [3:0] v, input logic [1:0] s);
      return v[s];
   endfunction

   // Register decode on word address
   function automatic logic is_reg(input logic [3:0] adr, input logic [3:0] ofs);
      return adr[3:2] == ofs[3:2];
   endfunction

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Delay stage select, code 3 acts as two stages
   function automatic logic [1:0] stg(input logic [1:0] d0, input logic [1:0] d1,
                                      input logic [1:0] d2, input logic [1:0] n);
      case (n)
         2'h0: return d0;
         2'h1: return d1;
         default: return d2;
      endcase
   endfunction

   // Input shift: 9-bit lanes take the upper chain bits
   function automatic logic [71:0] shift_word(input logic [71:0] r, input logic [17:0] c,
                                              input logic w9);
      if (w9) begin
         return {r[62:0], c[17:9]};
      end
      return {r[53:0], c};
   endfunction

   // Full-precision multipliers with per-operand sign extension
   function automatic logic [143:0] multiply(input logic [71:0] a, input logic [71:0] b,
                                             input maas_pkg::maas_width_t w,
                                             input logic sa, input logic sb);
      logic [143:0] r;
      logic signed [19:0] p9;
      logic signed [37:0] p18;
      logic signed [73:0] p36;
      r = '0;
      p9 = '0;
      p18 = '0;
      p36 = '0;
      case (w)
         maas_pkg::W9: begin
            for (int k = 0; k < 8; k++) begin
               p9 = $signed({sa & a[9*k+8], a[9*k +: 9]}) *
                    $signed({sb & b[9*k+8], b[9*k +: 9]});
               r[18*k +: 18] = p9[17:0];
            end
         end
         maas_pkg::W18: begin
            for (int k = 0; k < 4; k++) begin
               p18 = $signed({sa & a[18*k+17], a[18*k +: 18]}) *
                     $signed({sb & b[18*k+17], b[18*k +: 18]});
               r[36*k +: 36] = p18[35:0];
            end
         end
         default: begin
            p36 = $signed({sa & a[35], a[35:0]}) * $signed({sb & b[35], b[35:0]});
            r[71:0] = p36[71:0];
         end
      endcase
      return r;
   endfunction

   // One product lane, sign extended when the product is signed
   function automatic logic signed [53:0] lane(input logic [143:0] p, input int k,
                                               input logic w9, input logic sg);
      logic [35:0] v;
      v = '0;
      if (w9) begin
         v[17:0] = p[18*k +: 18];
         return {{36{sg & v[17]}}, v[17:0]};
      end
      v = p[36*(k%4) +: 36];
      return {{18{sg & v[35]}}, v};
   endfunction

   maas_pkg::maas_cfg_t cfg_reg;
   maas_pkg::maas_mode_t eff_mode;
   maas_pkg::maas_ctl_t ctl_in;
   maas_pkg::maas_ctl_t ctl_s1_reg;
   maas_pkg::maas_ctl_t ctl_s2_reg;
   logic [31:0] cfg_next;
   logic [71:0] a_reg;
   logic [71:0] b_reg;
   logic [71:0] a_mul;
   logic [71:0] b_mul;
   logic [143:0] prod_comb;
   logic [143:0] prod_reg;
   logic [143:0] prod;
   logic [143:0] out_comb;
   logic [143:0] result_reg;
   logic [1:0] ovf_reg;
   logic [1:0] mul_sign;
   logic [1:0] add_sign;
   logic [1:0] addnsub_eff;
   logic [1:0] sload_eff;
   logic [1:0] acc_ovf;
   logic [3:0] op_add;
   logic signed [53:0] r [4];
   logic signed [53:0] s [2];
   logic signed [53:0] acc_l [2];
   logic [ACC_W:0] acc_x [2];
   logic [ACC_W-1:0] acc_v [2];
   logic en_a, en_b, en_p, en_o;
   logic clr_a, clr_b, clr_p, clr_o;
   logic w9, shift_on, in_used, out_reg_on, prod_signed, wb_hit, wb_wr;

   // Wishbone slave: answer one cycle after the strobe, write on the ack edge
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign cfg_next = merge({9'h000, cfg_reg}, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (wb_hit) begin
         if (is_reg(wb_adr_i, `MAAS_CFG_OFS)) begin
            wb_dat_o <= {9'h000, cfg_reg};
         end else if (is_reg(wb_adr_i, `MAAS_STAT_OFS)) begin
            wb_dat_o <= {29'h00000000, out_reg_on, ovf_reg};
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= maas_pkg::maas_cfg_t'(`MAAS_CFG_RST);
      end else if (wb_wr && is_reg(wb_adr_i, `MAAS_CFG_OFS)) begin
         cfg_reg <= maas_pkg::maas_cfg_t'(cfg_next[`MAAS_CFG_W-1:0]);
      end
   end

   // Set selection per register group
   assign en_a = pick(ena_i, cfg_reg.a_set); // RULE1
   assign en_b = pick(ena_i, cfg_reg.b_set); // RULE1
   assign en_p = pick(ena_i, cfg_reg.pipe_set);
   assign en_o = pick(ena_i, cfg_reg.out_set); // RULE18
   assign clr_a = pick(aclr_i, cfg_reg.a_set);
   assign clr_b = pick(aclr_i, cfg_reg.b_set);
   assign clr_p = pick(aclr_i, cfg_reg.pipe_set);
   assign clr_o = pick(aclr_i, cfg_reg.out_set);

   assign w9 = cfg_reg.width == maas_pkg::W9;
   assign eff_mode = cfg_reg.width[1] ? maas_pkg::M_SIMPLE : cfg_reg.mode; // RULE21
   assign shift_on = cfg_reg.shift_en & ~cfg_reg.width[1]; // RULE4
   assign in_used = cfg_reg.in_reg_en | shift_on;
   assign out_reg_on = cfg_reg.out_reg_en | (eff_mode == maas_pkg::M_ACC); // RULE10

   // Dynamic control delay stages
   assign ctl_in = '{sign: {sign_a_i, sign_b_i}, addnsub: addnsub_i, sload: accum_sload_i};

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_a) begin
         ctl_s1_reg <= '0; // RULE22
      end else if (en_a) begin
         ctl_s1_reg <= ctl_in;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_p) begin
         ctl_s2_reg <= '0; // RULE22
      end else if (en_p) begin
         ctl_s2_reg <= ctl_s1_reg;
      end
   end

   assign mul_sign = cfg_reg.sign_mul_reg ? ctl_s1_reg.sign : ctl_in.sign; // RULE7
   assign add_sign = stg(ctl_in.sign, ctl_s1_reg.sign, ctl_s2_reg.sign,
                         cfg_reg.sign_stg); // RULE13
   assign addnsub_eff = stg(ctl_in.addnsub, ctl_s1_reg.addnsub, ctl_s2_reg.addnsub,
                            cfg_reg.addsub_stg); // RULE12
   assign sload_eff = stg(ctl_in.sload, ctl_s1_reg.sload, ctl_s2_reg.sload,
                          cfg_reg.sload_stg); // RULE14
   assign prod_signed = add_sign[1] | add_sign[0]; // RULE6

   // Input registers, parallel load or shift chain
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_a) begin
         a_reg <= '0; // RULE22
      end else if (en_a) begin
         a_reg <= shift_on ? shift_word(a_reg, chain_in_first_operand_i, w9) : op_a_i; // RULE2
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_b) begin
         b_reg <= '0; // RULE22
      end else if (en_b) begin
         b_reg <= shift_on ? shift_word(b_reg, chain_in_second_operand_i, w9) : op_b_i; // RULE2
      end
   end

   assign a_mul = in_used ? a_reg : op_a_i;
   assign b_mul = in_used ? b_reg : op_b_i;
   assign chain_out_first_operand_o = a_reg[71:54]; // RULE3
   assign chain_out_second_operand_o = b_reg[71:54]; // RULE3

   // Multipliers and post-multiply pipeline
   assign prod_comb = multiply(a_mul, b_mul, cfg_reg.width, mul_sign[1], mul_sign[0]); // RULE5 RULE8

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_p) begin
         prod_reg <= '0; // RULE22
      end else if (en_p) begin
         prod_reg <= prod_comb; // RULE9
      end
   end

   assign prod = cfg_reg.pipe_en ? prod_reg : prod_comb; // RULE9

   // First-level adders take only products
   for (genvar j = 0; j < 4; j++) begin : g_add
      assign op_add[j] = w9 ? addnsub_eff[j/2] : addnsub_eff[j%2];
      assign r[j] = op_add[j] ? lane(prod, 2*j, w9, prod_signed) + lane(prod, 2*j+1, w9, prod_signed)
                              : lane(prod, 2*j, w9, prod_signed) - lane(prod, 2*j+1, w9, prod_signed); // RULE11 RULE19
   end

   // Summation of first-level results
   assign s[0] = r[0] + r[1]; // RULE16
   assign s[1] = r[2] + r[3]; // RULE16

   // Accumulators fed back from the output register
   for (genvar i = 0; i < 2; i++) begin : g_acc
      logic [ACC_W-1:0] cur;
      logic [ACC_W:0] cur_ext;
      logic [ACC_W:0] sum;
      assign acc_l[i] = lane(prod, w9 ? 2 + 4*i : 1 + 2*i, w9, prod_signed);
      assign acc_x[i] = acc_l[i][ACC_W:0];
      assign cur = result_reg[72*i +: ACC_W];
      assign cur_ext = {prod_signed & cur[ACC_W-1], cur};
      assign sum = addnsub_eff[i] ? cur_ext + acc_x[i] : cur_ext - acc_x[i]; // RULE14 RULE20
      assign acc_v[i] = sload_eff[i] ? acc_x[i][ACC_W-1:0] : sum[ACC_W-1:0]; // RULE14
      assign acc_ovf[i] = ~sload_eff[i] &
                          (prod_signed ? (sum[ACC_W] ^ sum[ACC_W-1]) : sum[ACC_W]); // RULE15
   end

   // Output selection
   always_comb begin
      out_comb = '0;
      case (eff_mode)
         maas_pkg::M_SIMPLE: begin
            out_comb = prod; // RULE17
         end
         maas_pkg::M_ACC: begin
            for (int i = 0; i < 2; i++) begin
               out_comb[72*i +: ACC_W] = acc_v[i]; // RULE17
            end
         end
         maas_pkg::M_ADD2: begin
            if (w9) begin
               for (int j = 0; j < 4; j++) begin
                  out_comb[36*j +: 36] = r[j][35:0];
               end
            end else begin
               out_comb[53:0] = r[0];
               out_comb[125:72] = r[1];
            end
         end
         maas_pkg::M_ADD4: begin
            out_comb[53:0] = s[0]; // RULE17
            if (w9) begin
               out_comb[125:72] = s[1];
            end
         end
         default: begin
            out_comb = prod;
         end
      endcase
   end

   // Output register, loaded every cycle when bypassed
   always_ff @(posedge clk_i) begin
      if (rst_i || (out_reg_on && clr_o)) begin
         result_reg <= '0; // RULE22
      end else if (!out_reg_on || en_o) begin
         result_reg <= out_comb; // RULE18
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_o || eff_mode != maas_pkg::M_ACC) begin
         ovf_reg <= 2'h0;
      end else if (en_o) begin
         ovf_reg <= acc_ovf; // RULE15
      end
   end

   assign result_o = result_reg;
   assign overflow_o = ovf_reg;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic signed [37:0] exp_p0;
   assign exp_p0 = $signed({mul_sign[1] & a_mul[17], a_mul[17:0]}) *
                   $signed({mul_sign[0] & b_mul[17], b_mul[17:0]});

   chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_in_b_hold: assert property ((!en_b && !clr_b) |=> $stable(b_reg)) // RULE1
      else $error("B input register changed without enable");
   chk_shift_chain: assert property ((shift_on && !w9 && en_a && !clr_a) |=> // RULE2
      (a_reg[35:18] == $past(a_reg[17:0]) && a_reg[17:0] == $past(chain_in_first_operand_i)))
      else $error("input shift chain did not advance");
   chk_wide_parallel: assert property ((cfg_reg.width == maas_pkg::W36 && en_a && !clr_a) // RULE4
      |=> a_reg == $past(op_a_i))
      else $error("wide mode did not load parallel input");
   chk_prod_sign: assert property ((cfg_reg.width == maas_pkg::W18 && eff_mode == maas_pkg::M_SIMPLE // RULE6
      && !cfg_reg.pipe_en && !cfg_reg.out_reg_en) |=> result_o[35:0] == $past(exp_p0[35:0]))
      else $error("product lane wrong");
   chk_acc_forced: assert property ((eff_mode == maas_pkg::M_ACC && !cfg_reg.out_reg_en // RULE10
      && !en_o && !clr_o) |=> $stable(result_o))
      else $error("accumulator output not registered");
   chk_acc_sload: assert property ((eff_mode == maas_pkg::M_ACC && en_o && !clr_o // RULE14
      && sload_eff[0]) |=> result_o[ACC_W-1:0] == $past(acc_x[0][ACC_W-1:0]))
      else $error("accumulator load missed product");
   chk_ovf_follow: assert property ((eff_mode == maas_pkg::M_ACC && en_o && !clr_o) // RULE15
      |=> overflow_o[0] == $past(acc_ovf[0]))
      else $error("overflow flag wrong");
   chk_out_hold: assert property ((cfg_reg.out_reg_en && !en_o && !clr_o) |=> // RULE18
      $stable(result_o))
      else $error("output register changed without enable");
   chk_out_clear: assert property ((out_reg_on && clr_o) |=> // RULE22
      (result_o == '0 && overflow_o == 2'h0))
      else $error("clear did not zero output");

endmodule

`default_nettype wire

// file: test/maas_fabric.sv
// Fabric-side model feeding the multiply/add/accumulate slice.
// Assumes the bench loads its inputs by non-blocking assignment on clk_i.
`timescale 1ns/1ps
`default_nettype none
module maas_fabric (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Values from the bench
   input wire logic [71:0] a_i,
   input wire logic [71:0] b_i,
   input wire logic [1:0] sg_i,
   input wire logic [1:0] ans_i,
   input wire logic [1:0] sl_i,
   input wire logic [3:0] ena_i,
   input wire logic [3:0] clr_i,
   input wire logic [1:0] ovf_i,
   // Toward the slice
   output logic [71:0] a_o,
   output logic [71:0] b_o,
   output logic [1:0] sg_o,
   output logic [1:0] ans_o,
   output logic [1:0] sl_o,
   output logic [3:0] ena_o,
   output logic [3:0] clr_o,
   output logic [1:0] ovf_held_o
);
   // Operands and controls launched from one fabric register stage
   always_ff @(posedge clk_i) begin
      a_o <= a_i;
      b_o <= b_i;
      sg_o <= sg_i;
      ans_o <= ans_i;
      sl_o <= sl_i;
      ena_o <= ena_i;
      clr_o <= clr_i;
   end
   // Fabric keeps its own latched copy of the overflow flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_held_o <= 2'h0;
      end else begin
         ovf_held_o <= ovf_held_o | ovf_i;
      end
   end
endmodule
`default_nettype wire

// file: test/tb_maas_slice.sv
// Self-checking bench for the multiply/add/accumulate slice.
// Assumes the slice, its package and constants header are compiled first.
`include "maas_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_maas_slice;
   localparam logic [71:0] OPA = 72'h9A3C5F0E817D24B6C3;
   localparam logic [71:0] OPB = 72'h4FE2A79130C85BD6E9;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [143:0] res;
   logic [1:0] ovf, ovf_held, m_sg, m_ans, m_sl;
   logic [71:0] f_a = 72'h0, f_b = 72'h0, m_a, m_b;
   logic [1:0] f_sg = 2'h0, f_ans = 2'h3, f_sl = 2'h0;
   logic [3:0] f_ena = 4'hF, f_clr = 4'h0, m_ena, m_clr;
   logic [17:0] ch_a = 18'h0, ch_b = 18'h0, co_a, co_b;
   int fail_count = 0, cmp_count = 0, cyc_n = 0;

   always #2.5 clk_i = ~clk_i;

   maas_fabric FAB (.clk_i(clk_i), .rst_i(rst_i), .a_i(f_a), .b_i(f_b), .sg_i(f_sg),
      .ans_i(f_ans), .sl_i(f_sl), .ena_i(f_ena), .clr_i(f_clr), .ovf_i(ovf), .a_o(m_a),
      .b_o(m_b), .sg_o(m_sg), .ans_o(m_ans), .sl_o(m_sl), .ena_o(m_ena), .clr_o(m_clr),
      .ovf_held_o(ovf_held));

   maas_slice DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ena_i(m_ena), .aclr_i(m_clr),
      .op_a_i(m_a), .op_b_i(m_b), .sign_a_i(m_sg[1]), .sign_b_i(m_sg[0]),
      .addnsub_i(m_ans), .accum_sload_i(m_sl), .chain_in_first_operand_i(ch_a),
      .chain_in_second_operand_i(ch_b), .chain_out_first_operand_o(co_a),
      .chain_out_second_operand_o(co_b), .result_o(res), .overflow_o(ovf));

   // Full-precision product of two w-bit lanes, two's complement when signed
   function automatic logic [71:0] mul(input logic [35:0] a, input logic [35:0] b,
      input int w, input logic sa, input logic sb);
      logic [71:0] x, y, m;
      m = (72'h1 << w) - 72'h1;
      x = {36'h0, a} & m;
      y = {36'h0, b} & m;
      if (sa && x[w-1]) x = x | ~m;
      if (sb && y[w-1]) y = y | ~m;
      m = (w == 36) ? ~72'h0 : (72'h1 << (2 * w)) - 72'h1;
      return (x * y) & m;
   endfunction

   task chk(input logic [71:0] got, input logic [71:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic Wishbone single cycle, held until ack is sampled
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk({40'h0, q}, {40'h0, exp});
   endtask

   task step(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task drive(input logic [71:0] a, input logic [71:0] b, input logic [1:0] sg);
      f_a <= a;
      f_b <= b;
      f_sg <= sg;
   endtask

   task done(input string s);
      $display("test %s done", s);
   endtask

   task end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 4000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      logic [71:0] p[4];
      logic [71:0] e;
      logic [31:0] q;
      int k, j;
      step(16);
      rst_i <= 1'b0;
      step(1);
      rd_chk(`MAAS_CFG_OFS, 32'h0);
      rd_chk(`MAAS_STAT_OFS, 32'h0);
      wr(4'h8, 32'h5A);
      rd_chk(4'h8, 32'h0);
      wr(`MAAS_CFG_OFS, 32'h1540D1);
      rd_chk(`MAAS_CFG_OFS, 32'h1540D1);
      done("registers");
      wr(`MAAS_CFG_OFS, 32'h1);
      for (k = 0; k < 4; k++) begin
         drive(OPA, OPB, k[1:0]);
         step(3);
         for (j = 0; j < 4; j++) begin
            chk({36'h0, res[36*j+:36]}, mul(OPA[18*j+:18], OPB[18*j+:18], 18, k[1], k[0]));
         end
      end
      done("mul18");
      wr(`MAAS_CFG_OFS, 32'h0);
      drive(OPA, OPB, 2'b10);
      step(3);
      for (j = 0; j < 8; j++) begin
         chk({54'h0, res[18*j+:18]}, mul({27'h0, OPA[9*j+:9]}, {27'h0, OPB[9*j+:9]}, 9, 1, 0));
      end
      wr(`MAAS_CFG_OFS, 32'h22);
      drive(OPA, OPB, 2'b11);
      step(3);
      chk(res[71:0], mul(OPA[35:0], OPB[35:0], 36, 1, 1));
      done("mul9 mul36");
      wr(`MAAS_CFG_OFS, 32'h9);
      f_ans <= 2'b10;
      drive(OPA, OPB, 2'b00);
      step(3);
      for (j = 0; j < 4; j++) p[j] = mul(OPA[18*j+:18], OPB[18*j+:18], 18, 0, 0);
      e = p[0] - p[1];
      chk({18'h0, res[53:0]}, {18'h0, e[53:0]});
      e = p[2] + p[3];
      chk({18'h0, res[125:72]}, {18'h0, e[53:0]});
      wr(`MAAS_CFG_OFS, 32'hD);
      f_ans <= 2'b11;
      step(3);
      e = p[0] + p[1] + p[2] + p[3];
      chk({18'h0, res[53:0]}, {18'h0, e[53:0]});
      done("adders");
      wr(`MAAS_CFG_OFS, 32'h5);
      wb(1'b0, `MAAS_STAT_OFS, 32'h0, q);
      chk({71'h0, q[2]}, 72'h1);
      f_sl <= 2'b11;
      step(1);
      f_sl <= 2'b00;
      step(2);
      chk({20'h0, res[51:0]}, p[1]);
      chk({20'h0, res[123:72]}, p[3]);
      step(1);
      chk({20'h0, res[51:0]}, p[1] << 1);
      chk({70'h0, ovf_held}, 72'h0);
      done("accumulate");
      wr(`MAAS_CFG_OFS, 32'h1540D1);
      drive(OPB, OPB, 2'b00);
      e = mul(OPB[17:0], OPB[17:0], 18, 0, 0);
      k = 0;
      for (j = 1; j <= 8; j++) begin
         @(posedge clk_i);
         if (k == 0 && res[35:0] === e[35:0]) k = j;
      end
      chk({40'h0, k}, 72'h5);
      f_ena <= 4'hD;
      drive(OPA, OPB, 2'b00);
      step(8);
      chk({36'h0, res[35:0]}, e);
      f_clr <= 4'h2;
      step(3);
      chk({36'h0, res[35:0]}, 72'h0);
      f_clr <= 4'h0;
      done("pipeline enable clear");
      wr(`MAAS_CFG_OFS, 32'h21);
      ch_a <= 18'h2A5B3;
      ch_b <= 18'h1C94E;
      step(5);
      chk({54'h0, co_a}, 72'h2A5B3);
      chk({54'h0, co_b}, 72'h1C94E);
      chk({36'h0, res[35:0]}, mul({18'h0, 18'h2A5B3}, {18'h0, 18'h1C94E}, 18, 0, 0));
      done("shift chain");
      end_sim();
   end
endmodule
`default_nettype wire
